//--- design/ppfc_pkg.sv
// ppfc_pkg: constants, register map and state types of the pause block
// assumes one 100 MHz core clock and an AXI4-Lite master outside
package ppfc_pkg;

	// =====================================================================
	// register map (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_ISR = 8'h08;
	localparam logic [7:0] OFS_ICLR = 8'h0c;
	localparam logic [7:0] OFS_IEN = 8'h10;
	localparam logic [7:0] OFS_SA1_LO = 8'h14;
	localparam logic [7:0] OFS_SA1_HI = 8'h18;
	localparam logic [7:0] OFS_TXPFC = 8'h1c;
	localparam logic [7:0] OFS_TXPQ = 8'h20;
	localparam logic [7:0] OFS_PFTX = 8'h24;
	localparam logic [7:0] OFS_PACT = 8'h28;

	// =====================================================================
	// field positions
	localparam int CTRL_TXEN = 3;
	localparam int CTRL_PFCTX = 17;
	localparam int CFG_FDX = 1;
	localparam int CFG_RTEST = 12;
	localparam int IRQ_PEXP = 13;
	localparam int IRQ_PTX = 14;

	// =====================================================================
	// reset values and frame constants
	localparam logic [15:0] TXPQ_RST = 16'hffff;
	localparam logic [47:0] PFC_DA = 48'h0180c2000001;
	localparam logic [15:0] PFC_TYPE = 16'h8808;
	localparam logic [15:0] PFC_OPC = 16'h0101;
	localparam logic [5:0] HDR_LEN = 6'h12;
	localparam logic [5:0] QEND = 6'h22;
	localparam logic [5:0] DATA_LEN = 6'h3c;
	localparam logic [5:0] LAST_IDX = 6'h3f;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam int PQ_BIT_TIMES = 512;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_DEC = 2'h3;

	// =====================================================================
	// state
	typedef enum logic [1:0] {ST_IDLE, ST_NORM, ST_PAUSE} ppfc_tx_e;

	typedef struct packed {
		logic [1:0] rx_sy;
		logic rx_prev;
		logic [8:0] qdiv;
		logic [7:0][15:0] pt;
		logic [7:0] pact;
		logic [1:0] isr;
		logic [1:0] ien;
		logic irq;
		logic tx_en;
		logic fdx;
		logic rtest;
		logic [47:0] sa;
		logic [15:0] pfc;
		logic [15:0] pq;
		logic [31:0] pfcnt;
		logic pend;
		logic [7:0] vec;
		logic [7:0] zm;
		logic [15:0] q;
		ppfc_tx_e st;
		logic [5:0] idx;
		logic [31:0] crc;
		logic [7:0] txd;
		logic txv;
		logic txl;
		logic ntake;
		logic aw_f;
		logic [7:0] awa;
		logic w_f;
		logic [31:0] wd;
		logic [3:0] ws;
		logic awr;
		logic wr;
		logic bv;
		logic [1:0] bresp;
		logic arr;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rresp;
	} ppfc_state_s;

endpackage : ppfc_pkg

//--- design/ppfc_top.sv
// ppfc_top: priority pause receive timers and pause frame generator
// assumes rx parser and tx serializer on clk_i; line clock from a pin
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps

module ppfc_top import ppfc_pkg::*; #(
	parameter int RX_BITS_PER_CLK = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// receive side
	input wire logic receive_line_clock_i,
	input wire logic rx_pfc_valid_i,
	input wire logic [7:0] rx_pfc_vec_i,
	input wire logic [7:0][15:0] rx_pfc_quanta_i,
	output logic [7:0] rx_pause_active_o,
	// normal frame path
	input wire logic norm_valid_i,
	input wire logic [7:0] norm_data_i,
	input wire logic norm_last_i,
	output logic norm_take_o,
	// byte stream to serializer
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	output logic tx_last_o,
	input wire logic tx_ready_i,
	// interrupt
	output logic irq_o
);

	// =====================================================================
	// helpers
	localparam int QDIV = PQ_BIT_TIMES / RX_BITS_PER_CLK;
	localparam logic [8:0] QDIV_MAX = 9'(QDIV - 1);

	function automatic logic [31:0] ppfc_crc8(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int b = 0; b < 8; b++) begin
			r = (r[0] ^ d[b]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : ppfc_crc8

	function automatic logic [7:0] ppfc_fbyte(input logic [5:0] i, input logic [47:0] sa,
		input logic [7:0] v, input logic [7:0] zm, input logic [15:0] q);
		logic [143:0] hdr;
		logic [2:0] k;
		logic [15:0] qq;
		logic [7:0] b;
		hdr = {PFC_DA, sa, PFC_TYPE, PFC_OPC, 8'h00, v};
		k = 3'((i - HDR_LEN) >> 1);
		qq = zm[k] ? 16'h0000 : q;
		// past the quanta the byte stays zero: the pad up to the fcs
		b = 8'h00;
		if (i < HDR_LEN) begin
			b = hdr[8 * (int'(HDR_LEN) - 1 - int'(i)) +: 8];
		end else if (i < QEND) begin
			b = i[0] ? qq[7:0] : qq[15:8];
		end
		return b;
	endfunction : ppfc_fbyte

	// byte strobes pick which lanes of the old value are replaced
	function automatic logic [31:0] ppfc_wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[8 * b +: 8] = d[8 * b +: 8];
			end
		end
		return r;
	endfunction : ppfc_wmerge

	ppfc_state_s s;
	ppfc_state_s n;

	// =====================================================================
	// next state
	always_comb begin
		logic edge_seen;
		logic tick;
		logic zero_ev;
		logic taken;
		logic [31:0] wv;
		logic [31:0] fcs;
		logic [7:0] byt;
		logic [7:0] wa;
		logic [7:0] ra;
		logic [7:0] ld;
		edge_seen = 1'b0;
		tick = 1'b0;
		zero_ev = 1'b0;
		taken = 1'b0;
		wv = 32'h0;
		fcs = 32'h0;
		byt = 8'h00;
		wa = 8'h00;
		ra = 8'h00;
		ld = rx_pfc_valid_i ? rx_pfc_vec_i : 8'h00;
		n = s;
		n.ntake = 1'b0;

		// line clock seen only through the two-flop synchroniser
		// the first flop feeds nothing but the second; metastability stays there
		n.rx_sy = {s.rx_sy[0], receive_line_clock_i};
		n.rx_prev = s.rx_sy[1];
		edge_seen = s.rx_sy[1] & ~s.rx_prev;

		// pause timers
		if (s.rtest) begin
			// test mode: no divider, one step per line edge once tx is quiet
			tick = edge_seen & (s.st == ST_IDLE) & ~s.txv;
		end else if (edge_seen) begin
			// one wrap of the divider is 512 bit times of line edges
			n.qdiv = (s.qdiv == QDIV_MAX) ? 9'h000 : s.qdiv + 9'h001;
			tick = (s.qdiv == QDIV_MAX);
		end
		// a same-cycle load wins, so its timer raises no expiry from the old count
		for (int p = 0; p < 8; p++) begin
			if (tick && s.pt[p] != 16'h0000 && !ld[p]) begin
				n.pt[p] = s.pt[p] - 16'h0001;
				if (s.pt[p] == 16'h0001) begin
					zero_ev = 1'b1;
				end
			end
		end
		// a new frame restarts the 512 bit-time window
		if (rx_pfc_valid_i) begin
			n.qdiv = 9'h000;
			for (int p = 0; p < 8; p++) begin
				if (rx_pfc_vec_i[p]) begin
					n.pt[p] = rx_pfc_quanta_i[p];
					if (rx_pfc_quanta_i[p] == 16'h0000) begin
						zero_ev = 1'b1;
					end
				end
			end
		end
		for (int p = 0; p < 8; p++) begin
			n.pact[p] = (n.pt[p] != 16'h0000);
		end

		// transmit arbiter; one bubble per byte keeps norm_take_o registered
		taken = s.txv & tx_ready_i;
		if (taken) begin
			n.txv = 1'b0;
			n.txl = 1'b0;
		end
		case (s.st)
			ST_IDLE: begin
				// pending pause wins the gap before the next queued frame
				if (s.pend) begin
					n.st = ST_PAUSE;
					n.pend = 1'b0;
					n.idx = 6'h00;
					n.crc = CRC_INIT;
				end else if (norm_valid_i) begin
					n.st = ST_NORM;
				end
			end
			ST_NORM: begin
				if (taken && s.txl) begin
					n.st = ST_IDLE;
				end else if (!s.txv && norm_valid_i) begin
					// take pulse next cycle: the source moves on at the edge after
					n.txd = norm_data_i;
					n.txv = 1'b1;
					n.txl = norm_last_i;
					n.ntake = 1'b1;
				end
			end
			ST_PAUSE: begin
				if (taken && s.txl) begin
					n.st = ST_IDLE;
					n.pfcnt = s.pfcnt + 32'h1;
				end else if (!s.txv) begin
					if (s.idx < DATA_LEN) begin
						byt = ppfc_fbyte(s.idx, s.sa, s.vec, s.zm, s.q);
						n.crc = ppfc_crc8(s.crc, byt);
					end else begin
						// fcs goes out least significant byte first
						fcs = ~s.crc;
						byt = fcs[8 * int'(s.idx - DATA_LEN) +: 8];
					end
					n.txd = byt;
					n.txv = 1'b1;
					n.txl = (s.idx == LAST_IDX);
					n.idx = s.idx + 6'h01;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// axi write channels, taken in either order
		if (s_axi_awvalid_i && s.awr) begin
			n.aw_f = 1'b1;
			n.awa = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s.wr) begin
			n.w_f = 1'b1;
			n.wd = s_axi_wdata_i;
			n.ws = s_axi_wstrb_i;
		end
		if (s.bv && s_axi_bready_i) begin
			n.bv = 1'b0;
		end
		if (s.aw_f && s.w_f && !s.bv) begin
			n.aw_f = 1'b0;
			n.w_f = 1'b0;
			n.bv = 1'b1;
			n.bresp = RESP_OK;
			wa = {s.awa[7:2], 2'b00};
			case (wa)
				OFS_CTRL: begin
					wv = ppfc_wmerge({28'h0, s.tx_en, 3'h0}, s.wd, s.ws);
					n.tx_en = wv[CTRL_TXEN];
					// request judged on the enables held before this write
					if (wv[CTRL_PFCTX] && s.tx_en && s.fdx) begin
						n.pend = 1'b1;
						n.vec = s.pfc[7:0];
						n.zm = s.pfc[15:8];
						n.q = s.pq;
					end
				end
				OFS_CFG: begin
					wv = ppfc_wmerge({19'h0, s.rtest, 10'h0, s.fdx, 1'b0}, s.wd, s.ws);
					n.fdx = wv[CFG_FDX];
					n.rtest = wv[CFG_RTEST];
				end
				OFS_ICLR: begin
					wv = ppfc_wmerge(32'h0, s.wd, s.ws);
					n.isr = s.isr & ~wv[IRQ_PTX:IRQ_PEXP];
				end
				OFS_IEN: begin
					wv = ppfc_wmerge({17'h0, s.ien, 13'h0}, s.wd, s.ws);
					n.ien = wv[IRQ_PTX:IRQ_PEXP];
				end
				OFS_SA1_LO: begin
					n.sa[31:0] = ppfc_wmerge(s.sa[31:0], s.wd, s.ws);
				end
				OFS_SA1_HI: begin
					wv = ppfc_wmerge({16'h0, s.sa[47:32]}, s.wd, s.ws);
					n.sa[47:32] = wv[15:0];
				end
				OFS_TXPFC: begin
					wv = ppfc_wmerge({16'h0, s.pfc}, s.wd, s.ws);
					n.pfc = wv[15:0];
				end
				OFS_TXPQ: begin
					wv = ppfc_wmerge({16'h0, s.pq}, s.wd, s.ws);
					n.pq = wv[15:0];
				end
				OFS_ISR, OFS_PFTX, OFS_PACT: begin
					n.bresp = RESP_OK;
				end
				default: begin
					n.bresp = RESP_DEC;
				end
			endcase
		end

		// status events after the clear so a same-cycle event survives
		if (zero_ev) begin
			n.isr[0] = 1'b1;
		end
		if (s.st == ST_PAUSE && taken && s.txl) begin
			n.isr[1] = 1'b1;
		end
		// built from next flags so irq_o moves in step with the status bits
		n.irq = |(n.isr & n.ien);

		// axi read channel
		if (s.rv && s_axi_rready_i) begin
			n.rv = 1'b0;
		end
		if (s_axi_arvalid_i && s.arr) begin
			n.rv = 1'b1;
			n.rresp = RESP_OK;
			// unmapped reads answer zero with a decode error
			ra = {s_axi_araddr_i[7:2], 2'b00};
			case (ra)
				OFS_CTRL: n.rd = {28'h0, s.tx_en, 3'h0};
				OFS_CFG: n.rd = {19'h0, s.rtest, 10'h0, s.fdx, 1'b0};
				OFS_ISR: n.rd = {17'h0, s.isr, 13'h0};
				OFS_IEN: n.rd = {17'h0, s.ien, 13'h0};
				OFS_SA1_LO: n.rd = s.sa[31:0];
				OFS_SA1_HI: n.rd = {16'h0, s.sa[47:32]};
				OFS_TXPFC: n.rd = {16'h0, s.pfc};
				OFS_TXPQ: n.rd = {16'h0, s.pq};
				OFS_PFTX: n.rd = s.pfcnt;
				OFS_PACT: n.rd = {24'h0, s.pact};
				OFS_ICLR: n.rd = 32'h0;
				default: begin
					n.rd = 32'h0;
					n.rresp = RESP_DEC;
				end
			endcase
		end

		// readies drop while a transfer is held or answered
		n.awr = ~n.aw_f & ~n.bv;
		n.wr = ~n.w_f & ~n.bv;
		n.arr = ~n.rv;
	end

	// =====================================================================
	// state register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			// pause quantum alone resets to all ones
			s <= '0;
			s.pq <= TXPQ_RST;
		end else begin
			s <= n;
		end
	end

	// =====================================================================
	// outputs
	assign s_axi_awready_o = s.awr;
	assign s_axi_wready_o = s.wr;
	assign s_axi_bresp_o = s.bresp;
	assign s_axi_bvalid_o = s.bv;
	assign s_axi_arready_o = s.arr;
	assign s_axi_rdata_o = s.rd;
	assign s_axi_rresp_o = s.rresp;
	assign s_axi_rvalid_o = s.rv;
	assign rx_pause_active_o = s.pact;
	assign norm_take_o = s.ntake;
	assign tx_data_o = s.txd;
	assign tx_valid_o = s.txv;
	assign tx_last_o = s.txl;
	assign irq_o = s.irq;

endmodule : ppfc_top

//--- tb/ppfc_props.sv
// ppfc_props: port checks of the pause block
// assumes binding into ppfc_top
`timescale 1ns/100ps
module ppfc_props #(
	parameter int RX_BITS_PER_CLK = 4
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic rx_pfc_valid_i,
	input wire logic [7:0] rx_pfc_vec_i,
	input wire logic [7:0][15:0] rx_pfc_quanta_i,
	input wire logic [7:0] rx_pause_active_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_valid_o,
	input wire logic tx_last_o,
	input wire logic tx_ready_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write answer dropped");
	chk_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
		else $error("read answer dropped");
	chk_aw_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
		else $error("write ready while answering");
	chk_ar_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read ready while answering");
	chk_tx_hold: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_data_o, tx_last_o}))
		else $error("tx byte changed before taken");
	chk_tx_gap: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
		else $error("no gap after taken byte");
	chk_load_act: assert property (
		rx_pfc_valid_i && rx_pfc_vec_i[0] && rx_pfc_quanta_i[0] != 16'h0000
		|-> ##[1:2] rx_pause_active_o[0]) else $error("timer not loaded");
	chk_rise_cause: assert property (
		$rose(rx_pause_active_o[0]) |-> $past(rx_pfc_valid_i && rx_pfc_vec_i[0], 2)
		|| $past(rx_pfc_valid_i && rx_pfc_vec_i[0])) else $error("timer rose unloaded");
endmodule : ppfc_props
bind ppfc_top ppfc_props #(.RX_BITS_PER_CLK(RX_BITS_PER_CLK)) u_chk (
	.clk_i(clk_i),
	.nrst_i(nrst_i),
	.s_axi_awready_o(s_axi_awready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i),
	.s_axi_arready_o(s_axi_arready_o),
	.s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i),
	.rx_pfc_valid_i(rx_pfc_valid_i),
	.rx_pfc_vec_i(rx_pfc_vec_i),
	.rx_pfc_quanta_i(rx_pfc_quanta_i),
	.rx_pause_active_o(rx_pause_active_o),
	.tx_data_o(tx_data_o),
	.tx_valid_o(tx_valid_o),
	.tx_last_o(tx_last_o),
	.tx_ready_i(tx_ready_i)
);

//--- tb/ppfc_sink.sv
// ppfc_sink: serializer model that collects the tx byte stream
// assumes the registered byte stream of ppfc_top
`timescale 1ns/100ps
module ppfc_sink (
	// stream in
	input wire logic clk_i,
	input wire logic [7:0] d_i,
	input wire logic v_i,
	input wire logic l_i,
	// handshake and capture
	output logic rdy_o,
	output logic [7:0] fr_o [256],
	output int n_o,
	output int e_o,
	output int lp_o
);
	initial begin
		rdy_o = 1'b0;
		n_o = 0;
		e_o = 0;
		lp_o = -1;
	end
	// ready alternates each cycle, so only a byte offered while it is low meets a stall
	always @(posedge clk_i) begin
		rdy_o <= ~rdy_o;
		if (v_i && rdy_o) begin
			fr_o[n_o[7:0]] <= d_i;
			n_o <= n_o + 1;
			if (l_i) begin
				e_o <= e_o + 1;
				lp_o <= n_o;
			end
		end
	end
endmodule : ppfc_sink

//--- tb/testbench.sv
// testbench: register, frame and timer checks of the pause block
// assumes ppfc_top, ppfc_sink and ppfc_props compiled first
`timescale 1ns/100ps
module testbench;
	import ppfc_pkg::*;
	logic clk_i, nrst_i, lck, awv, wv, bre, arv, rre, rxv, nv, nl, nt;
	logic awr, wr, bv, arr, rv, irq, tv, tl, trdy;
	logic [7:0] awa, ara, vec, pact, td, nd;
	logic [31:0] wd, rdo, rdat;
	logic [1:0] br, rr, wb, rb;
	logic [7:0][15:0] rq;
	logic [7:0] fr [256];
	int n_errors, checked, cyc, nb, ne, lp;
	ppfc_top #(.RX_BITS_PER_CLK(4)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_rdata_o(rdo), .s_axi_rresp_o(rr),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .receive_line_clock_i(lck),
		.rx_pfc_valid_i(rxv), .rx_pfc_vec_i(vec), .rx_pfc_quanta_i(rq),
		.rx_pause_active_o(pact), .norm_valid_i(nv), .norm_data_i(nd),
		.norm_last_i(nl), .norm_take_o(nt), .tx_data_o(td), .tx_valid_o(tv),
		.tx_last_o(tl), .tx_ready_i(trdy), .irq_o(irq));
	ppfc_sink u_sink (.clk_i(clk_i), .d_i(td), .v_i(tv), .l_i(tl), .rdy_o(trdy), .fr_o(fr),
		.n_o(nb), .e_o(ne), .lp_o(lp));
	// =====================================================================
	// clocks; line clock offset so no edge meets a core edge
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		lck = 1'b0;
		#1;
		forever #62.5 lck = ~lck;
	end
	// =====================================================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (bv !== 1'b1);
		wb = br;
		bre <= 1'b0;
	endtask : wrr
	task automatic rdr(input logic [7:0] a);
		@(posedge clk_i);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		rdat = rdo;
		rb = rr;
		rre <= 1'b0;
	endtask : rdr
	task automatic rxf(input logic [7:0] v, input int p, input logic [15:0] q);
		@(posedge clk_i);
		vec <= v;
		rq[p] <= q;
		rxv <= 1'b1;
		@(posedge clk_i);
		rxv <= 1'b0;
	endtask : rxf
	// frame byte expected for vector a5, zero mask 0f, quantum 1234
	function automatic logic [7:0] eb(input int i);
		logic [143:0] h;
		h = {PFC_DA, 48'haabb11223344, PFC_TYPE, PFC_OPC, 8'h00, 8'ha5};
		if (i < 18) return h[143-8*i -: 8];
		if (i < 34) return (i < 26) ? 8'h00 : ((i % 2) ? 8'h34 : 8'h12);
		return 8'h00;
	endfunction : eb
	// one generated pause frame at offset o of the capture, fcs included
	task automatic chkfr(input int o);
		logic [31:0] c;
		logic [7:0] d;
		c = CRC_INIT;
		for (int i = 0; i < 60; i++) begin
			d = eb(i);
			chk("frame byte", d, fr[o + i]);
			for (int b = 0; b < 8; b++) begin
				c = (c[0] ^ d[b]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
			end
		end
		chk("frame fcs", ~c, {fr[o + 63], fr[o + 62], fr[o + 61], fr[o + 60]});
	endtask : chkfr
	// normal frame source; moves to the next byte after each take pulse
	task automatic nfr(input logic [7:0] b0, input int n);
		@(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			nd <= b0 + 8'(i);
			nl <= (i == n - 1);
			nv <= 1'b1;
			do begin
				@(posedge clk_i);
			end while (nt !== 1'b1);
		end
		nv <= 1'b0;
		nl <= 1'b0;
	endtask : nfr
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	// =====================================================================
	// sequence
	initial begin
		{nrst_i, awv, wv, bre, arv, rre, rxv, nv, nl} = '0;
		{awa, ara, vec, wd, rq, nd} = '0;
		{n_errors, checked, cyc} = '0;
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rdr(OFS_TXPQ);
		chk("txpq reset", 32'h0000ffff, rdat);
		wrr(8'hfc, 32'h1);
		chk("bresp", RESP_DEC, wb);
		rdr(8'hfc);
		chk("rresp", RESP_DEC, rb);
		wrr(OFS_CTRL, 32'h00020000);
		repeat (200) @(posedge clk_i);
		chk("frame without tx enable", 0, nb);
		wrr(OFS_CFG, 32'h2);
		wrr(OFS_CTRL, 32'h8);
		wrr(OFS_IEN, 32'h6000);
		wrr(OFS_SA1_LO, 32'h11223344);
		wrr(OFS_SA1_HI, 32'haabb);
		wrr(OFS_TXPFC, 32'h0fa5);
		wrr(OFS_TXPQ, 32'h1234);
		wrr(OFS_CTRL, 32'h20008);
		for (int i = 0; i < 3000 && nb < 64; i++) @(posedge clk_i);
		chkfr(0);
		chk("first frame ends", 1, ne);
		chk("first last index", 63, lp);
		repeat (4) @(posedge clk_i);
		rdr(OFS_PFTX);
		chk("pause sent count", 1, rdat);
		rdr(OFS_ISR);
		chk("isr after send", 32'h4000, rdat);
		chk("irq after send", 1, irq);
		wrr(OFS_ICLR, 32'h4000);
		chk("irq cleared", 0, irq);
		// pause requested mid-frame must slot in before the queued frame
		fork
			begin
				nfr(8'h40, 8);
				nfr(8'h50, 8);
			end
			begin
				repeat (6) @(posedge clk_i);
				wrr(OFS_CTRL, 32'h20008);
			end
		join
		for (int i = 0; i < 3000 && nb < 144; i++) @(posedge clk_i);
		for (int i = 0; i < 8; i++) chk("first normal byte", 8'h40 + i, fr[64 + i]);
		chkfr(72);
		for (int i = 0; i < 8; i++) chk("second normal byte", 8'h50 + i, fr[136 + i]);
		chk("frame ends", 4, ne);
		chk("last byte index", 143, lp);
		repeat (4) @(posedge clk_i);
		rdr(OFS_PFTX);
		chk("pause count after normal frames", 2, rdat);
		rdr(OFS_ISR);
		chk("isr second send", 32'h4000, rdat);
		wrr(OFS_ICLR, 32'h4000);
		rxf(8'h01, 0, 16'd2);
		repeat (2500) @(posedge clk_i);
		chk("timer running", 1, pact[0]);
		repeat (1200) @(posedge clk_i);
		chk("timer expired", 0, pact[0]);
		rdr(OFS_ISR);
		chk("isr expiry", 32'h2000, rdat);
		chk("irq expiry", 1, irq);
		wrr(OFS_ICLR, 32'h2000);
		wrr(OFS_IEN, 32'h4000);
		rxf(8'h02, 1, 16'd0);
		repeat (4) @(posedge clk_i);
		rdr(OFS_ISR);
		chk("isr zero quantum", 32'h2000, rdat);
		chk("irq masked", 0, irq);
		wrr(OFS_CFG, 32'h1002);
		rxf(8'h04, 2, 16'd3);
		repeat (100) @(posedge clk_i);
		chk("retry test fast count", 0, pact[2]);
		tally_and_finish();
	end
endmodule : testbench
